//--- verilog/adc_input_select_control_defines.vh
// Register offsets, field positions, reset values and codes of the input select control
`ifndef ADC_INPUT_SELECT_CONTROL_DEFINES_VH
`define ADC_INPUT_SELECT_CONTROL_DEFINES_VH

// ----------------------------------------------------------------
// Special-function register addresses
// ----------------------------------------------------------------
`define ADDR_INPUT_SELECT     8'hD7
`define ADDR_CONV_CTRL_ZERO   8'hDC
`define ADDR_CONV_CTRL_ONE    8'hDD
`define ADDR_PERIPH_IRQ_STAT  8'hA7
`define ADDR_AUX_IRQ          8'hA6
`define ADDR_RESULT_LOW       8'hD9
`define ADDR_RESULT_MID       8'hDA
`define ADDR_RESULT_HIGH      8'hDB

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_INPUT_SELECT      8'h01
`define RST_CONV_CTRL_ZERO    8'h00
`define RST_CONV_CTRL_ONE     8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define POS_MSB               7
`define POS_LSB               4
`define NEG_MSB               3
`define NEG_LSB               0
`define BIT_BURNOUT           6
`define BIT_BUFFER            3
`define GAIN_MSB              2
`define BIT_READY             5
`define CAL_MSB               2

// ----------------------------------------------------------------
// Selector codes
// ----------------------------------------------------------------
`define SEL_COMMON            4'h8
`define SEL_TEMP_ALL          8'hFF
`define CAL_NONE              3'h0
`define CAL_RSVD_LO           3'h6

`endif

//--- verilog/sample_fifo.v
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps

module sample_fifo #(
	parameter WIDTH = 24,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire             core_clk,
	input  wire             rst_b,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);

	reg [WIDTH-1:0] mem_r [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_r;
	reg [AW-1:0]    rd_ptr_r;
	reg [AW:0]      count_r;
	wire            push;
	wire            pop;

	// ----------------------------------------------------------------
	// Flags and handshakes
	// ----------------------------------------------------------------
	assign in_ready  = (count_r != DEPTH[AW:0]);
	assign out_valid = (count_r != {(AW+1){1'b0}});
	assign out_data  = mem_r[rd_ptr_r];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Storage has no reset; count guards every read
	always @(posedge core_clk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data;
		end
	end

	// Pointers wrap; depth must be a power of two
	always @(posedge core_clk) begin
		if (!rst_b) begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r  <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end

endmodule

//--- verilog/adc_input_select_control.v
// Input select, front-end control and result path of the delta-sigma converter
`timescale 1ns/1ps
`include "adc_input_select_control_defines.vh"

// How it works
// - Input select register sits at SFR address D7h, read and write.
// - Bits 7..4 choose the source for the positive converter input.
// - Bits 3..0 choose the source for the negative converter input.
// - Positive codes 0..7 pick analog inputs 0..7; code 8 picks common.
// - Negative codes use the same encoding as the positive selector.
// - Only FFh disconnects all pins and connects the temperature diodes.
// - Any pin may be positive or negative; no fixed pairing is imposed.
// - Input select resets to 01h: input 0 positive, input 1 negative.
// - Control zero bit 6 switches the burnout current sources on or off.
// - Control zero bit 3 enables the input buffer; clear bypasses it.
// - Ready flag at mask 20h sets on a new result; reading result clears.
// - Each result handed to the processor is 24 bits wide.
// - Control zero bits 2..0 select gain as a power of two, 1..128.
// - Calibration end raises the ready event, seen in status bit 5.
module adc_input_select_control #(
	parameter RES_W      = 24,
	parameter FIFO_DEPTH = 4,
	parameter FIFO_AW    = 2
) (
	input  wire             core_clk,
	input  wire             rst_b,
	input  wire [7:0]       sfr_addr,
	input  wire [7:0]       sfr_wdata,
	input  wire             sfr_wr,
	input  wire             sfr_rd,
	output reg  [7:0]       sfr_rdata,
	input  wire             conv_valid,
	output reg              conv_ready,
	input  wire [RES_W-1:0] conv_data,
	input  wire             cal_done,
	output reg  [8:0]       pos_route,
	output reg  [8:0]       neg_route,
	output reg              temp_diode_en,
	output reg              burnout_source_enable,
	output reg              buffer_enable,
	output reg  [2:0]       amplifier_gain_setting,
	output reg  [2:0]       cal_mode,
	output reg              cal_start,
	output reg              conversion_ready_flag
);

	// ----------------------------------------------------------------
	// Registers and wires
	// ----------------------------------------------------------------
	reg  [7:0]       input_select_r;
	reg  [7:0]       converter_control_zero_r;
	reg  [7:0]       converter_control_one_r;
	reg  [RES_W-1:0] result_r;
	reg  [FIFO_AW:0] fill_r;
	reg  [FIFO_AW:0] fill_nxt;
	wire             conv_push;
	reg              result_full_r;
	reg              ready_nxt;
	reg              pos_temp_nxt;
	reg  [8:0]       pos_nxt;
	reg  [8:0]       neg_nxt;
	reg  [7:0]       rdata_nxt;
	wire             fifo_valid;
	wire [RES_W-1:0] fifo_data;
	wire             fifo_pop;
	wire             result_read;
	wire             all_temp;
	wire             wr_sel;
	wire             wr_c0;
	wire             wr_c1;

	assign wr_sel = sfr_wr && (sfr_addr == `ADDR_INPUT_SELECT);
	assign wr_c0  = sfr_wr && (sfr_addr == `ADDR_CONV_CTRL_ZERO);
	assign wr_c1  = sfr_wr && (sfr_addr == `ADDR_CONV_CTRL_ONE);

	// Reading the high byte last completes a result read
	assign result_read = sfr_rd && (sfr_addr == `ADDR_RESULT_HIGH);
	assign all_temp    = (input_select_r == `SEL_TEMP_ALL);

	// Next result moves up once the holding register is free
	assign fifo_pop = fifo_valid && (!result_full_r || result_read);

	// A result is accepted only while the registered ready stands
	assign conv_push = conv_valid && conv_ready;

	// ----------------------------------------------------------------
	// Result buffer
	// ----------------------------------------------------------------
	// Buffers results so a slow processor stalls the converter, not loses data
	sample_fifo #(
		.WIDTH (RES_W),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_fifo (
		.core_clk  (core_clk),
		.rst_b     (rst_b),
		.in_valid  (conv_push),
		.in_ready  (),
		.in_data   (conv_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_data)
	);

	// Mirror of the FIFO fill, so ready leaves on a flop with no extra latency
	always @* begin
		fill_nxt = fill_r;
		if (conv_push && !fifo_pop) begin
			fill_nxt = fill_r + 1'b1;
		end else if (fifo_pop && !conv_push) begin
			fill_nxt = fill_r - 1'b1;
		end
	end

	// Ready drops at the edge that takes the last free slot
	always @(posedge core_clk) begin
		if (!rst_b) begin
			fill_r     <= {(FIFO_AW+1){1'b0}};
			conv_ready <= 1'b0;
		end else begin
			fill_r     <= fill_nxt;
			conv_ready <= (fill_nxt != FIFO_DEPTH[FIFO_AW:0]);
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	// Software-written settings
	always @(posedge core_clk) begin
		if (!rst_b) begin
			input_select_r           <= `RST_INPUT_SELECT;
			converter_control_zero_r <= `RST_CONV_CTRL_ZERO;
			converter_control_one_r  <= `RST_CONV_CTRL_ONE;
		end else begin
			if (wr_sel) begin
				input_select_r <= sfr_wdata;
			end
			if (wr_c0) begin
				converter_control_zero_r <= sfr_wdata;
			end
			if (wr_c1) begin
				converter_control_one_r <= sfr_wdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// Result holding and ready flag
	// ----------------------------------------------------------------
	// Set wins over clear so a result landing during a read still flags
	always @* begin
		ready_nxt = conversion_ready_flag;
		if (result_read) begin
			ready_nxt = 1'b0;
		end
		if (fifo_pop || cal_done) begin
			ready_nxt = 1'b1;
		end
	end

	always @(posedge core_clk) begin
		if (!rst_b) begin
			result_r              <= {RES_W{1'b0}};
			result_full_r         <= 1'b0;
			conversion_ready_flag <= 1'b0;
		end else begin
			conversion_ready_flag <= ready_nxt;
			if (fifo_pop) begin
				result_r      <= fifo_data;
				result_full_r <= 1'b1;
			end else if (result_read) begin
				result_full_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Multiplexer decode
	// ----------------------------------------------------------------
	// Nibbles decode independently; no pairing check between them
	always @* begin
		pos_nxt      = 9'h000;
		neg_nxt      = 9'h000;
		pos_temp_nxt = all_temp;
		if (!all_temp) begin
			if (input_select_r[`POS_MSB:`POS_LSB] <= `SEL_COMMON) begin
				pos_nxt[input_select_r[`POS_MSB:`POS_LSB]] = 1'b1;
			end
			if (input_select_r[`NEG_MSB:`NEG_LSB] <= `SEL_COMMON) begin
				neg_nxt[input_select_r[`NEG_MSB:`NEG_LSB]] = 1'b1;
			end
		end
		// Codes 9..15 other than all-ones leave the input open
	end

	// ----------------------------------------------------------------
	// Front-end outputs
	// ----------------------------------------------------------------
	// Registered so analog switches see no decode glitches
	always @(posedge core_clk) begin
		if (!rst_b) begin
			pos_route              <= 9'h001;
			neg_route              <= 9'h002;
			temp_diode_en          <= 1'b0;
			burnout_source_enable  <= 1'b0;
			buffer_enable          <= 1'b0;
			amplifier_gain_setting <= 3'h0;
			cal_mode               <= `CAL_NONE;
			cal_start              <= 1'b0;
		end else begin
			pos_route              <= pos_nxt;
			neg_route              <= neg_nxt;
			temp_diode_en          <= pos_temp_nxt;
			burnout_source_enable  <= converter_control_zero_r[`BIT_BURNOUT];
			buffer_enable          <= converter_control_zero_r[`BIT_BUFFER];
			amplifier_gain_setting <= converter_control_zero_r[`GAIN_MSB:0];
			cal_mode               <= converter_control_one_r[`CAL_MSB:0];
			// Reserved calibration codes start nothing
			cal_start <= wr_c1 && (sfr_wdata[`CAL_MSB:0] != `CAL_NONE) &&
				(sfr_wdata[`CAL_MSB:0] < `CAL_RSVD_LO);
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	// Unmapped addresses read as zero
	always @* begin
		case (sfr_addr)
			`ADDR_INPUT_SELECT: begin
				rdata_nxt = input_select_r;
			end
			`ADDR_CONV_CTRL_ZERO: begin
				rdata_nxt = converter_control_zero_r;
			end
			`ADDR_CONV_CTRL_ONE: begin
				rdata_nxt = converter_control_one_r;
			end
			`ADDR_AUX_IRQ: begin
				rdata_nxt = {2'b00, conversion_ready_flag, 5'b00000};
			end
			`ADDR_PERIPH_IRQ_STAT: begin
				rdata_nxt = {2'b00, conversion_ready_flag, 5'b00000};
			end
			`ADDR_RESULT_LOW: begin
				rdata_nxt = result_r[7:0];
			end
			`ADDR_RESULT_MID: begin
				rdata_nxt = result_r[15:8];
			end
			`ADDR_RESULT_HIGH: begin
				rdata_nxt = result_r[23:16];
			end
			default: begin
				rdata_nxt = 8'h00;
			end
		endcase
	end

	always @(posedge core_clk) begin
		if (!rst_b) begin
			sfr_rdata <= 8'h00;
		end else begin
			sfr_rdata <= rdata_nxt;
		end
	end

endmodule

//--- test/adc_input_select_control_checker.sv
// Port assertions of the input select control
`timescale 1ns/1ps
module adc_input_select_control_checker (
	input logic       core_clk,
	input logic       rst_b,
	input logic [7:0] sfr_addr,
	input logic [7:0] sfr_wdata,
	input logic       sfr_wr,
	input logic       sfr_rd,
	input logic [7:0] sfr_rdata,
	input logic       cal_done,
	input logic       cal_start,
	input logic       conv_valid,
	input logic       conv_ready,
	input logic [8:0] pos_route,
	input logic [8:0] neg_route,
	input logic       temp_diode_en,
	input logic       burnout_source_enable,
	input logic       buffer_enable,
	input logic [2:0] amplifier_gain_setting,
	input logic       conversion_ready_flag
);
	// Routes and controls lag a write by two edges, so their checks look two back
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	wire [3:0] w_pos = sfr_wdata[7:4];
	wire [3:0] w_neg = sfr_wdata[3:0];
	wire [2:0] w_gain = sfr_wdata[2:0];
	function automatic logic [8:0] route(input logic [3:0] n);
		return (n < 4'h9) ? (9'h001 << n) : 9'h000;
	endfunction
	sequence wr_sel;
		sfr_wr && sfr_addr == 8'hD7;
	endsequence
	sequence hold_sel;
		(sfr_addr == 8'hD7 && !sfr_wr) [*2];
	endsequence
	a_sel_readback: assert property (wr_sel ##1 hold_sel |=>
		sfr_rdata == $past(sfr_wdata, 3)) else $error("select readback wrong");
	a_pos_route: assert property (wr_sel |-> ##2
		pos_route == route($past(w_pos, 2))) else $error("positive route wrong");
	a_neg_route: assert property (wr_sel |-> ##2
		neg_route == route($past(w_neg, 2))) else $error("negative route wrong");
	a_temp_only_ff: assert property (wr_sel |-> ##2
		temp_diode_en == ($past(sfr_wdata, 2) == 8'hFF)) else $error("diode select wrong");
	a_burnout_ctrl: assert property (sfr_wr && sfr_addr == 8'hDC |-> ##2
		burnout_source_enable == |($past(sfr_wdata, 2) & 8'h40)) else $error("burnout wrong");
	a_buffer_ctrl: assert property (sfr_wr && sfr_addr == 8'hDC |-> ##2
		buffer_enable == |($past(sfr_wdata, 2) & 8'h08)) else $error("buffer wrong");
	a_gain_ctrl: assert property (sfr_wr && sfr_addr == 8'hDC |-> ##2
		amplifier_gain_setting == $past(w_gain, 2)) else $error("gain wrong");
	// Unread results; a result pushed last edge is not yet in the holding register
	logic [3:0] pend;
	logic       push_d;
	wire        push_now = conv_valid && conv_ready;
	wire        rd_high  = sfr_rd && sfr_addr == 8'hDB;
	wire        held     = pend > 4'h1 || (pend == 4'h1 && !push_d);
	always @(posedge core_clk) begin
		if (!rst_b) begin
			pend   <= 4'h0;
			push_d <= 1'b0;
		end else begin
			push_d <= push_now;
			pend   <= pend + {3'h0, push_now} - {3'h0, rd_high && held};
		end
	end
	a_flag_clear: assert property (rd_high && !cal_done && held && pend == 4'h1 |=>
		!conversion_ready_flag) else $error("ready flag not cleared");
	a_flag_refill: assert property (rd_high && held && pend > 4'h1 |=>
		conversion_ready_flag) else $error("queued result not flagged");
	a_status_view: assert property (sfr_addr == 8'hA7 |=>
		sfr_rdata == {2'b00, $past(conversion_ready_flag), 5'b00000})
		else $error("status bit wrong");
	a_cal_start: assert property (sfr_wr && sfr_addr == 8'hDD |=>
		cal_start == ($past(sfr_wdata[2:0]) != 3'h0 && $past(sfr_wdata[2:0]) < 3'h6))
		else $error("calibration start wrong");
	a_cal_flag: assert property (cal_done |=> conversion_ready_flag)
		else $error("calibration end not flagged");
endmodule
bind adc_input_select_control adc_input_select_control_checker chk (.core_clk, .rst_b,
	.sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .cal_done, .pos_route, .neg_route,
	.temp_diode_en, .burnout_source_enable, .buffer_enable, .amplifier_gain_setting,
	.conversion_ready_flag, .cal_start, .conv_valid, .conv_ready);

//--- test/sensor_model.sv
// Converter far side: offers results and ends calibrations
`timescale 1ns/1ps
module sensor_model (
	input  wire        core_clk,
	input  wire        gen_en,
	input  wire        cal_start,
	input  wire        conv_ready,
	output reg         conv_valid = 1'b0,
	output reg  [23:0] conv_data = 24'h000000,
	output reg         cal_done = 1'b0
);
	integer cal_cnt = 0;
	reg     taken;
	// Offer held until taken; idle data toggles so a stale value never passes
	always @(posedge core_clk) begin
		taken = conv_valid && conv_ready;
		#1;
		cal_done = 1'b0;
		if (cal_start)
			cal_cnt = 7;  // Shortened calibration time
		else if (cal_cnt > 0) begin
			cal_cnt = cal_cnt - 1;
			cal_done = (cal_cnt == 0);
		end
		if (taken || !conv_valid) begin
			conv_valid = gen_en && ($urandom_range(1, 0) == 1);
			conv_data = conv_valid ? 24'($urandom) : ~conv_data;
		end
	end
endmodule

//--- test/adc_input_select_control_tb.sv
// Self-checking bench of the input select control
`timescale 1ns/1ps
module adc_input_select_control_tb;
	reg core_clk = 1'b0, rst_b = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, gen_en = 1'b0;
	reg [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, v, rd_b;
	reg [23:0] got, want, q[$];
	wire [7:0] sfr_rdata;
	wire [23:0] conv_data;
	wire [8:0] pos_route, neg_route;
	wire [2:0] amplifier_gain_setting, cal_mode;
	wire conv_valid, conv_ready, cal_done, cal_start, temp_diode_en;
	wire burnout_source_enable, buffer_enable, conversion_ready_flag;
	integer bad_count = 0, comparisons = 0, cycles = 0, i;
	adc_input_select_control uut (.core_clk, .rst_b, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd,
		.sfr_rdata, .conv_valid, .conv_ready, .conv_data, .cal_done, .pos_route, .neg_route,
		.temp_diode_en, .burnout_source_enable, .buffer_enable, .amplifier_gain_setting,
		.cal_mode, .cal_start, .conversion_ready_flag);
	sensor_model far (.core_clk, .gen_en, .cal_start, .conv_ready, .conv_valid, .conv_data,
		.cal_done);
	// Clock, watchdog and the model queue of accepted results
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles = cycles + 1;
		if (conv_valid && conv_ready)
			q.push_back(conv_data);
		if (cycles == 5000) begin
			bad_count = bad_count + 1;
			report_and_stop;
		end
	end
	function [8:0] route(input [3:0] n);
		route = (n < 4'h9) ? (9'h001 << n) : 9'h000;
	endfunction
	task check(input [31:0] seen, input [31:0] expd);
		comparisons = comparisons + 1;
		if (seen !== expd) begin
			bad_count = bad_count + 1;
			$display("ERROR %0t seen %h expected %h", $time, seen, expd);
		end
	endtask
	task settle(input integer n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// One access; read data taken one edge after the address, before a reload
	task bus(input [7:0] a, input [7:0] d, input w);
		settle(1);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = w;
		sfr_rd = !w;
		settle(1);
		rd_b = sfr_rdata;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
	endtask
	task sel(input [7:0] s);
		bus(8'hD7, s, 1'b1);
		bus(8'hD7, 8'h00, 1'b0);
		check(rd_b, s);
		check(pos_route, route(s[7:4]));
		check(neg_route, route(s[3:0]));
		check(temp_diode_en, s == 8'hFF);
	endtask
	// Waits for the flag, reads low byte first, compares or discards
	task fetch(input keep);
		integer k;
		for (k = 0; k < 40 && conversion_ready_flag !== 1'b1; k = k + 1)
			settle(1);
		check(conversion_ready_flag, 1'b1);
		bus(keep ? 8'hA6 : 8'hA7, 8'h00, 1'b0);
		check(rd_b, 8'h20);
		for (k = 0; k < 3; k = k + 1) begin
			bus(8'hD9 + 8'(k), 8'h00, 1'b0);
			got = {rd_b, got[23:8]};
		end
		if (q.size() > 0)
			want = q.pop_front();
		if (keep)
			check(got, want);
	endtask
	task report_and_stop;
		$display("Mismatches %0d of %0d comparisons", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		i = $urandom(32'h8C27DC61);
		settle(5);
		rst_b = 1'b1;
		check(pos_route, 9'h001);
		check(neg_route, 9'h002);
		bus(8'hD7, 8'h00, 1'b0);
		check(rd_b, 8'h01);
		bus(8'hC3, 8'h5A, 1'b1);
		bus(8'hC3, 8'h00, 1'b0);
		check(rd_b, 8'h00);
		sel(8'h16);
		sel(8'hFF);
		sel(8'h8E);
		for (i = 0; i < 24; i = i + 1)
			sel($urandom);
		// Every gain code, burnout and buffer bits at random
		for (i = 0; i < 8; i = i + 1) begin
			v = {5'($urandom), i[2:0]};
			bus(8'hDC, v, 1'b1);
			settle(2);
			check(burnout_source_enable, v[6]);
			check(buffer_enable, v[3]);
			check(amplifier_gain_setting, i);
		end
		// Fill until refused with nothing read, then drain
		gen_en = 1'b1;
		for (i = 0; i < 60 && conv_ready !== 1'b0; i = i + 1)
			settle(1);
		gen_en = 1'b0;
		check(q.size(), 5);
		for (i = 0; i < 8 && q.size() > 0; i = i + 1)
			fetch(1'b1);
		settle(4);
		check(conversion_ready_flag, 1'b0);
		// Reserved calibration code starts nothing, code 1 does
		bus(8'hDD, 8'h06, 1'b1);
		check(cal_start, 1'b0);
		settle(12);
		check(conversion_ready_flag, 1'b0);
		bus(8'hDD, 8'h01, 1'b1);
		check(cal_start, 1'b1);
		fetch(1'b0);
		check(cal_mode, 3'h1);
		gen_en = 1'b1;
		repeat (4)
			fetch(1'b0);
		repeat (3)
			fetch(1'b1);
		report_and_stop;
	end
endmodule
